/* adc_ctl_pkg.sv */
package adc_ctl_pkg;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] A_SIM0 = 8'h00;   // single mode cfg 0
   localparam logic [7:0] A_SIM1 = 8'h04;   // single_mode_cfg1
   localparam logic [7:0] A_SCM0 = 8'h08;   // scan mode cfg 0
   localparam logic [7:0] A_SCM1 = 8'h0C;   // scan_mode_cfg1
   localparam logic [7:0] A_STOP = 8'h10;   // stop control
   localparam logic [7:0] A_STAT = 8'h14;   // live status
   localparam logic [7:0] A_DATA = 8'h40;   // 8 result words
   localparam logic [7:0] A_DEND = 8'h5C;   // last result word
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int B_START = 0;     // cfg0: start
   localparam int B_DONE = 5;      // cfg0: completed flag
   localparam int B_CH_LSB = 8;    // cfg0: channel / last scan channel
   localparam int CH_W = 3;
   localparam int B_SHSEL = 0;     // cfg1: sample-and-hold method
   localparam int B_SPD = 1;       // cfg1: fast sample-and-hold speed
   localparam int B_STOPB = 0;     // conv_stop_bit
   localparam int B_VOID = 8;      // status: cfg touched while busy
   localparam int RES_W = 10;
   localparam int NCH = 8;
   // ***************************************************
   // reset values and timing counts (peripheral clocks)
   // ***************************************************
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam int DONE_VALID_CYC = 2;
   localparam logic [7:0] SAMP_SLOW_CYC = 8'h08;
   localparam logic [7:0] SAMP_FAST_CYC = 8'h04;
   localparam logic [7:0] BIT_SLOW_CYC = 8'h04;
   localparam logic [7:0] BIT_FAST_CYC = 8'h02;
   // ***************************************************
   // sequencer states
   // ***************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONV = 3'b100
   } seq_t;
endpackage

/* adc_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - writing one to the stop bit during a scan halts at once and each result word keeps its last stored value.
// - the completed flag is bit 5 of both cfg0 registers and is valid two clocks after a start.
// - sample-and-hold is used for both modes when either method select bit asks for it.
// - with sample-and-hold, fast speed is used for both modes when either speed bit asks for it.
module adc_ctl
   import adc_ctl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmp_hi,
   output logic sample_en,
   output logic sh_en,
   output logic fast_en,
   output logic [RES_W-1:0] dac_code,
   output logic [CH_W-1:0] chan_sel
);
   // ***************************************************
   // bus slave
   // ***************************************************
   logic wr_pend_ff, nxt_wr_pend;
   logic [7:0] waddr_ff, nxt_waddr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [31:0] rd_mux;
   logic addr_ok;

   // core state
   seq_t st_ff, nxt_st;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [3:0] bit_ff, nxt_bit;
   logic [RES_W-1:0] sar_ff, nxt_sar;
   logic [RES_W-1:0] dac_ff, nxt_dac;
   logic [CH_W-1:0] ch_ff, nxt_ch;
   logic [CH_W-1:0] sch_ff, nxt_sch, ech_ff, nxt_ech;
   logic scan_ff, nxt_scan;
   logic sdone_ff, nxt_sdone, cdone_ff, nxt_cdone;
   logic void_ff, nxt_void;
   logic ssh_ff, nxt_ssh, sspd_ff, nxt_sspd;
   logic csh_ff, nxt_csh, cspd_ff, nxt_cspd;
   logic samp_ff, nxt_samp, shen_ff, nxt_shen, fast_ff, nxt_fast;
   logic [NCH-1:0][RES_W-1:0] data_ff, nxt_data;
   logic busy, eff_sh, eff_fast, start_go, stop_go;
   logic [RES_W-1:0] res_now;

   // address phase decode, registered read data
   always_comb begin
      addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2) && (haddr[1:0] == 2'h0);
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         A_SIM0: rd_mux = {21'h0, sch_ff, 2'h0, sdone_ff, 5'h0};
         A_SIM1: rd_mux = {30'h0, sspd_ff, ssh_ff};
         A_SCM0: rd_mux = {21'h0, ech_ff, 2'h0, cdone_ff, 5'h0};
         A_SCM1: rd_mux = {30'h0, cspd_ff, csh_ff};
         A_STAT: rd_mux = {23'h0, void_ff, 2'h0, ch_ff, fast_ff, shen_ff, busy};
         default: begin
            if (haddr[7:0] >= A_DATA && haddr[7:0] <= A_DEND) begin
               rd_mux = {22'h0, data_ff[haddr[4:2]]};
            end
         end
      endcase
      nxt_wr_pend = addr_ok && hwrite;
      nxt_waddr = addr_ok ? haddr[7:0] : waddr_ff;
      nxt_rdata = (addr_ok && !hwrite) ? rd_mux : 32'h0000_0000;
   end

   // bus registers; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         waddr_ff <= 8'h00;
         rdata_ff <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         waddr_ff <= nxt_waddr;
         rdata_ff <= nxt_rdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   assign hrdata = rdata_ff;

   // ***************************************************
   // configuration and sequencer
   // ***************************************************
   assign busy = (st_ff != ST_IDLE);
   assign eff_sh = ssh_ff | csh_ff;
   assign eff_fast = eff_sh & (sspd_ff | cspd_ff);
   assign stop_go = wr_pend_ff && (waddr_ff == A_STOP) && hwdata[B_STOPB];
   assign start_go = wr_pend_ff && !busy && !stop_go && hwdata[B_START]
                     && ((waddr_ff == A_SIM0) || (waddr_ff == A_SCM0));
   assign res_now = cmp_hi ? (sar_ff | dac_ff) : sar_ff;

   // next values: cfg writes, start, stop, conversion steps
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      nxt_sar = sar_ff;
      nxt_ch = ch_ff;
      nxt_sch = sch_ff;
      nxt_ech = ech_ff;
      nxt_scan = scan_ff;
      nxt_sdone = sdone_ff;
      nxt_cdone = cdone_ff;
      nxt_void = void_ff;
      nxt_ssh = ssh_ff;
      nxt_sspd = sspd_ff;
      nxt_csh = csh_ff;
      nxt_cspd = cspd_ff;
      nxt_data = data_ff;
      // cfg writes land only while idle; stop does not count as a touch
      if (wr_pend_ff && waddr_ff != A_STOP) begin
         if (!busy) begin
            case (waddr_ff)
               A_SIM0: nxt_sch = hwdata[B_CH_LSB +: CH_W];
               A_SIM1: begin
                  nxt_ssh = hwdata[B_SHSEL];
                  nxt_sspd = hwdata[B_SPD];
               end
               A_SCM0: nxt_ech = hwdata[B_CH_LSB +: CH_W];
               A_SCM1: begin
                  nxt_csh = hwdata[B_SHSEL];
                  nxt_cspd = hwdata[B_SPD];
               end
               default: ;
            endcase
         end else if (waddr_ff <= A_SCM1 && !stop_go) begin
            nxt_void = 1'b1;
         end
      end
      if (stop_go) begin
         nxt_st = ST_IDLE;
         nxt_cnt = 8'h00;
      end else if (start_go) begin
         nxt_st = ST_SAMPLE;
         nxt_scan = (waddr_ff == A_SCM0);
         nxt_ch = (waddr_ff == A_SCM0) ? '0 : hwdata[B_CH_LSB +: CH_W];
         nxt_cnt = (eff_fast ? SAMP_FAST_CYC : SAMP_SLOW_CYC) - 8'h01;
         if (waddr_ff == A_SIM0) begin
            nxt_sdone = 1'b0;
         end else begin
            nxt_cdone = 1'b0;
         end
         nxt_void = 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: ;
            ST_SAMPLE: begin
               if (cnt_ff == 8'h00) begin
                  nxt_st = ST_CONV;
                  nxt_bit = 4'(RES_W - 1);
                  nxt_sar = '0;
                  nxt_cnt = (eff_fast ? BIT_FAST_CYC : BIT_SLOW_CYC) - 8'h01;
               end else begin
                  nxt_cnt = cnt_ff - 8'h01;
               end
            end
            ST_CONV: begin
               if (cnt_ff != 8'h00) begin
                  nxt_cnt = cnt_ff - 8'h01;
               end else if (bit_ff != 4'h0) begin
                  nxt_sar = res_now;
                  nxt_bit = bit_ff - 4'h1;
                  nxt_cnt = (eff_fast ? BIT_FAST_CYC : BIT_SLOW_CYC) - 8'h01;
               end else begin
                  // whole result moves in one edge, so a stop never leaves a partial word
                  nxt_data[ch_ff] = res_now;
                  if (scan_ff && ch_ff != ech_ff) begin
                     nxt_ch = ch_ff + 3'h1;
                     nxt_st = ST_SAMPLE;
                     nxt_cnt = (eff_fast ? SAMP_FAST_CYC : SAMP_SLOW_CYC) - 8'h01;
                  end else begin
                     nxt_st = ST_IDLE;
                     nxt_sdone = sdone_ff | !scan_ff;
                     nxt_cdone = cdone_ff | scan_ff;
                  end
               end
            end
            default: nxt_st = ST_IDLE;
         endcase
      end
      nxt_dac = (nxt_st == ST_CONV) ? (nxt_sar | (RES_W'(1) << nxt_bit)) : '0;
      // without hold the input is tracked through the whole conversion
      nxt_samp = (nxt_st == ST_SAMPLE) || (nxt_st == ST_CONV && !eff_sh);
      nxt_shen = eff_sh;
      nxt_fast = eff_fast;
   end

   // core registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 8'h00;
         bit_ff <= 4'h0;
         sar_ff <= '0;
         dac_ff <= '0;
         ch_ff <= '0;
         sch_ff <= '0;
         ech_ff <= '0;
         scan_ff <= 1'b0;
         sdone_ff <= 1'b0;
         cdone_ff <= 1'b0;
         void_ff <= 1'b0;
         ssh_ff <= CFG_RST[B_SHSEL];
         sspd_ff <= CFG_RST[B_SPD];
         csh_ff <= CFG_RST[B_SHSEL];
         cspd_ff <= CFG_RST[B_SPD];
         samp_ff <= 1'b0;
         shen_ff <= 1'b0;
         fast_ff <= 1'b0;
         data_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         sar_ff <= nxt_sar;
         dac_ff <= nxt_dac;
         ch_ff <= nxt_ch;
         sch_ff <= nxt_sch;
         ech_ff <= nxt_ech;
         scan_ff <= nxt_scan;
         sdone_ff <= nxt_sdone;
         cdone_ff <= nxt_cdone;
         void_ff <= nxt_void;
         ssh_ff <= nxt_ssh;
         sspd_ff <= nxt_sspd;
         csh_ff <= nxt_csh;
         cspd_ff <= nxt_cspd;
         samp_ff <= nxt_samp;
         shen_ff <= nxt_shen;
         fast_ff <= nxt_fast;
         data_ff <= nxt_data;
      end
   end
   assign sample_en = samp_ff;
   assign sh_en = shen_ff;
   assign fast_en = fast_ff;
   assign dac_code = dac_ff;
   assign chan_sel = ch_ff;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   stop_halts_a: assert property (stop_go |=> st_ff == ST_IDLE [*2])
      else $error("stop did not halt the sequencer");
   stop_keeps_a: assert property (stop_go && busy |=> $stable(data_ff))
      else $error("result words changed on stop");
   done_hold_a: assert property (start_go && waddr_ff == A_SIM0 |=> !sdone_ff [*2])
      else $error("single completed flag set within two clocks of start");
   scan_hold_a: assert property (start_go && waddr_ff == A_SCM0 |=> !cdone_ff [*2])
      else $error("scan completed flag set within two clocks of start");
   sh_either_a: assert property ((ssh_ff || csh_ff) && st_ff == ST_CONV |=> !samp_ff || st_ff != ST_CONV)
      else $error("input tracked during held conversion");
   fast_cnt_a: assert property (start_go && eff_fast |=> cnt_ff == 8'h03)
      else $error("fast sample count wrong");
   slow_cnt_a: assert property (start_go && !eff_fast |=> cnt_ff == 8'h07)
      else $error("slow sample count wrong");
   stop_novoid_a: assert property (stop_go |=> void_ff == $past(void_ff) || !$past(busy))
      else $error("stop write marked the result void");
   cfg_guard_a: assert property (busy && wr_pend_ff && !stop_go |=> $stable({ssh_ff, sspd_ff, csh_ff, cspd_ff}))
      else $error("cfg changed during conversion");

   single_done_c: cover property (st_ff == ST_CONV && !scan_ff ##1 sdone_ff);
   scan_done_c: cover property (scan_ff && $rose(cdone_ff));
   scan_stop_c: cover property (scan_ff && busy && stop_go);
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
   import adc_ctl_pkg::*;
;
   // ***************************************************
   // bench signals
   // ***************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic cmp_hi = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, sample_en, sh_en, fast_en;
   logic [RES_W-1:0] dac_code;
   logic [CH_W-1:0] chan_sel;
   logic [31:0] v;
   logic [2:0] c;
   int fails = 0;
   int num_checks = 0;
   int samp_cnt = 0;

   adc_ctl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cmp_hi(cmp_hi), .sample_en(sample_en),
      .sh_en(sh_en), .fast_en(fast_en), .dac_code(dac_code), .chan_sel(chan_sel));

   // clock and sample-phase cycle counter
   always #50 hclk = ~hclk;
   always @(posedge hclk) begin
      if (sample_en === 1'b1) samp_cnt++;
   end

   // ***************************************************
   // bus tasks and checking
   // ***************************************************
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_done(input logic [7:0] a);
      int n;
      n = 0;
      v = 32'h0;
      while (v[B_DONE] !== 1'b1 && n < 300) begin
         xfer(a, 1'b0, 32'h0, v);
         n++;
      end
      check(32'(v[B_DONE]), 32'h1);
   endtask

   // single conversion; expected sample-phase length from the cfg1 pair
   task automatic conv_single(input logic [2:0] ch, input logic [1:0] s1, input logic [1:0] c1);
      logic sh, fast;
      sh = s1[B_SHSEL] | c1[B_SHSEL];
      fast = sh & (s1[B_SPD] | c1[B_SPD]);
      wr(A_SIM1, {30'h0, s1});
      wr(A_SCM1, {30'h0, c1});
      xfer(A_STAT, 1'b0, 32'h0, v);
      check({30'h0, v[2:1]}, {30'h0, fast, sh});
      check({30'h0, fast_en, sh_en}, {30'h0, fast, sh});
      samp_cnt = 0;
      wr(A_SIM0, {21'h0, ch, 8'h01});
      xfer(A_SIM0, 1'b0, 32'h0, v);
      check(32'(v[B_DONE]), 32'h0);
      wait_done(A_SIM0);
      if (sh) begin
         check(32'(samp_cnt), fast ? 32'(SAMP_FAST_CYC) : 32'(SAMP_SLOW_CYC));
      end
      xfer(A_DATA + {3'h0, ch, 2'h0}, 1'b0, 32'h0, v);
      check(v, cmp_hi ? 32'h0000_03FF : 32'h0);
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ***************************************************
   // test sequence
   // ***************************************************
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values and an unmapped word
      xfer(A_SIM1, 1'b0, 32'h0, v);
      check(v, CFG_RST);
      xfer(8'h30, 1'b0, 32'h0, v);
      check(v, 32'h0);
      // every method and speed combination of both cfg1 registers, single mode conversions
      for (int i = 0; i < 16; i++) begin
         cmp_hi <= i[0];
         conv_single(i[2:0], i[1:0], i[3:2]);
      end
      // full scan with all ones
      cmp_hi <= 1'b1;
      wr(A_SIM1, 32'h0);
      wr(A_SCM1, 32'h0);
      wr(A_SCM0, 32'h0000_0701);
      wait_done(A_SCM0);
      for (int k = 0; k < NCH; k++) begin
         xfer(A_DATA + 8'(4 * k), 1'b0, 32'h0, v);
         check(v, 32'h0000_03FF);
      end
      // rescan with zeros, touch cfg while busy, then stop mid-scan
      cmp_hi <= 1'b0;
      wr(A_SCM0, 32'h0000_0701);
      repeat (100) @(posedge hclk);
      wr(A_SIM1, 32'h1);
      xfer(A_STAT, 1'b0, 32'h0, v);
      c = v[5:3];
      check({31'h0, v[B_VOID]}, 32'h1);
      xfer(A_SIM1, 1'b0, 32'h0, v);
      check(v, 32'h0);
      wr(A_STOP, 32'h1);
      xfer(A_STAT, 1'b0, 32'h0, v);
      check({23'h0, v[B_VOID], 7'h0, v[0]}, 32'h0000_0100);
      check({29'h0, chan_sel}, {29'h0, c});
      check({22'h0, dac_code}, 32'h0);
      xfer(A_DATA + {3'h0, c, 2'h0}, 1'b0, 32'h0, v);
      check(v, 32'h0000_03FF);
      xfer(A_DATA, 1'b0, 32'h0, v);
      check(v, (c == 3'h0) ? 32'h0000_03FF : 32'h0);
      xfer(A_SCM0, 1'b0, 32'h0, v);
      check(32'(v[B_DONE]), 32'h0);
      // cfg writable again once idle
      wr(A_SIM1, 32'h3);
      xfer(A_SIM1, 1'b0, 32'h0, v);
      check(v, 32'h3);
      complete_run();
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire
